/* File: rtl/pprl_rate_limiter.v */
`timescale 1ns/100ps
`include "pprl_regs.vh"
// lane index = port*4 + q: q0 tx queue0, q1 tx queue1, q2 rx queue2, q3 rx queue3.
// a byte passes on a lane in each cycle where byte_req and byte_ok are both high.
module pprl_rate_limiter (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [2:0] port_is_10m,
  input wire [2:0] tx_multi_queue_en,
  input wire [11:0] byte_req,
  output wire [11:0] byte_ok
);

  reg [7:0] rx_q [0:2];
  reg [7:0] tx_q [0:2];
  wire [2:0] spd_q;
  wire [2:0] mq_q;
  integer i;

  // lane layout: four lanes per port, one per shaped queue
  localparam integer NUM_LANES = 12;
  localparam integer LANES_PER_PORT = 4;
  localparam integer Q_TX1 = 1;
  localparam integer Q_RX2 = 2;
  localparam integer Q_RX3 = 3;

  function [`PPRL_KBPS_W-1:0] code_rate;
    input [3:0] code;
    begin
      case (code)
        4'h1: code_rate = `PPRL_R1;
        4'h2: code_rate = `PPRL_R2;
        4'h3: code_rate = `PPRL_R3;
        4'h4: code_rate = `PPRL_R4;
        4'h5: code_rate = `PPRL_R5;
        4'h6: code_rate = `PPRL_R6;
        4'h7: code_rate = `PPRL_R7;
        4'h8: code_rate = `PPRL_R8;
        4'h9: code_rate = `PPRL_R9;
        4'ha: code_rate = `PPRL_R10;
        4'hb: code_rate = `PPRL_R11;
        4'hc: code_rate = `PPRL_R12;
        4'hd: code_rate = `PPRL_R13;
        4'he: code_rate = `PPRL_R14;
        4'hf: code_rate = `PPRL_R15;
        default: code_rate = {`PPRL_KBPS_W{1'b0}};
      endcase
    end
  endfunction

  // speed and queue-mode levels come from other logic and pins; they are
  // slow levels, so a plain two-flop synchroniser per bit is enough
  pprl_sync #(
    .WIDTH(3)
  ) u_spd_sync (
    .mclk(mclk),
    .rst(rst),
    .din(port_is_10m),
    .dout_q(spd_q)
  );

  pprl_sync #(
    .WIDTH(3)
  ) u_mq_sync (
    .mclk(mclk),
    .rst(rst),
    .din(tx_multi_queue_en),
    .dout_q(mq_q)
  );

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        rx_q[i] <= `PPRL_REG_RESET;
        tx_q[i] <= `PPRL_REG_RESET;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `PPRL_P1_RX_ADDR: rx_q[0] <= reg_wdata;
        `PPRL_P1_TX_ADDR: tx_q[0] <= reg_wdata;
        `PPRL_P2_RX_ADDR: rx_q[1] <= reg_wdata;
        `PPRL_P2_TX_ADDR: tx_q[1] <= reg_wdata;
        `PPRL_P3_RX_ADDR: rx_q[2] <= reg_wdata;
        `PPRL_P3_TX_ADDR: tx_q[2] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data is registered; unmapped addresses read zero
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `PPRL_REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        `PPRL_P1_RX_ADDR: reg_rdata <= rx_q[0];
        `PPRL_P1_TX_ADDR: reg_rdata <= tx_q[0];
        `PPRL_P2_RX_ADDR: reg_rdata <= rx_q[1];
        `PPRL_P2_TX_ADDR: reg_rdata <= tx_q[1];
        `PPRL_P3_RX_ADDR: reg_rdata <= rx_q[2];
        `PPRL_P3_TX_ADDR: reg_rdata <= tx_q[2];
        default: reg_rdata <= `PPRL_REG_RESET;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g = g + 1) begin : lane
      localparam integer PORT = g / LANES_PER_PORT;
      localparam integer QUE = g % LANES_PER_PORT;
      wire [3:0] raw_code;
      wire [3:0] eff_code;
      wire limited;
      wire [`PPRL_KBPS_W-1:0] rate;

      if (QUE == Q_RX3) begin : q3
        assign raw_code = rx_q[PORT][`PPRL_HI_NIB];
      end else if (QUE == Q_RX2) begin : q2
        assign raw_code = rx_q[PORT][`PPRL_LO_NIB];
      end else if (QUE == Q_TX1) begin : q1
        // single-queue port: queue1 never limited
        assign raw_code = mq_q[PORT] ? tx_q[PORT][`PPRL_HI_NIB]
                                     : `PPRL_CODE_OFF;
      end else begin : q0
        assign raw_code = tx_q[PORT][`PPRL_LO_NIB];
      end

      // rates above 10 Mbps fall back to unlimited on a 10 Mbit/s port
      assign eff_code = (spd_q[PORT] && raw_code > `PPRL_CODE_10M_MAX) ?
                        `PPRL_CODE_OFF : raw_code;
      assign limited = (eff_code != `PPRL_CODE_OFF);
      assign rate = code_rate(eff_code);

      pprl_bucket u_bucket (
        .mclk(mclk),
        .rst(rst),
        .limited(limited),
        .rate(rate),
        .req(byte_req[g]),
        .ok(byte_ok[g])
      );
    end
  endgenerate

endmodule

// token bucket for one lane: it gains the coded rate in Kbps every cycle
// and pays eight bits times the clock rate in KHz for each byte passed
module pprl_bucket (
  input wire mclk,
  input wire rst,
  input wire limited,
  input wire [`PPRL_KBPS_W-1:0] rate,
  input wire req,
  output wire ok
);

  wire take;
  wire [`PPRL_CRED_W:0] gain;
  reg [`PPRL_CRED_W:0] sum;
  reg [`PPRL_CRED_W-1:0] cred_d;
  reg [`PPRL_CRED_W-1:0] cred_q;

  assign ok = !limited || (cred_q >= `PPRL_BYTE_COST);
  assign take = req && ok;
  assign gain = {{(`PPRL_CRED_W + 1 - `PPRL_KBPS_W){1'b0}}, rate};

  // the cap bounds a burst after a quiet spell to two bytes; an unlimited
  // lane sits at the cap, so a newly set code starts with that full burst
  always @* begin
    sum = {1'b0, cred_q} + gain;
    if (take && limited) begin
      sum = sum - {1'b0, `PPRL_BYTE_COST};
    end
    if (!limited || sum > {1'b0, `PPRL_CRED_CAP}) begin
      cred_d = `PPRL_CRED_CAP;
    end else begin
      cred_d = sum[`PPRL_CRED_W-1:0];
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cred_q <= `PPRL_CRED_CAP;
    end else begin
      cred_q <= cred_d;
    end
  end

endmodule

// two-flop synchroniser for level inputs from another domain; only the
// second flop is read, so a metastable first stage never reaches logic
module pprl_sync #(
  parameter WIDTH = 3
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout_q
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      dout_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end

endmodule

/* File: rtl/pprl_regs.vh */
// Summary of operation
// - per-port byte 7 high nibble: rx queue3 limit
// - per-port byte 7 low nibble: rx queue2 limit
// - per-port byte 8 high nibble: tx queue1 limit
// - per-port byte 8 low nibble: tx queue0 limit
// - shape each receive queue to its code
// - shape each transmit queue to its code
// - code zero unlimited; fields reset to zero
// - codes 1-8 map 64 Kbps to 8 Mbps
// - codes 9-15 map 16 to 88 Mbps
// - at 10 Mbit/s, codes above 10 Mbps unlimited
// - single tx queue: only queue0 limited
`ifndef PPRL_REGS_VH
`define PPRL_REGS_VH
`define PPRL_P1_RX_ADDR 8'h17
`define PPRL_P1_TX_ADDR 8'h18
`define PPRL_P2_RX_ADDR 8'h27
`define PPRL_P2_TX_ADDR 8'h28
`define PPRL_P3_RX_ADDR 8'h37
`define PPRL_P3_TX_ADDR 8'h38
`define PPRL_REG_RESET 8'h00
`define PPRL_HI_NIB 7:4
`define PPRL_LO_NIB 3:0
`define PPRL_CODE_OFF 4'h0
`define PPRL_CODE_10M_MAX 4'h8
// rates in Kbps
`define PPRL_KBPS_W 17
`define PPRL_R1 17'd64
`define PPRL_R2 17'd128
`define PPRL_R3 17'd256
`define PPRL_R4 17'd512
`define PPRL_R5 17'd1000
`define PPRL_R6 17'd2000
`define PPRL_R7 17'd4000
`define PPRL_R8 17'd8000
`define PPRL_R9 17'd16000
`define PPRL_R10 17'd32000
`define PPRL_R11 17'd48000
`define PPRL_R12 17'd64000
`define PPRL_R13 17'd72000
`define PPRL_R14 17'd80000
`define PPRL_R15 17'd88000
// clock in KHz; one byte costs 8 bits * clock KHz credit units
`define PPRL_CLK_KHZ 125000
`define PPRL_CRED_W 22
`define PPRL_BYTE_COST 22'd1000000
`define PPRL_CRED_CAP 22'd2000000
`endif

/* File: tb/pprl_chk_sva.sv */
`timescale 1ns/100ps
module pprl_chk (
  input wire mclk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [2:0] tx_multi_queue_en,
  input wire [11:0] byte_req,
  input wire [11:0] byte_ok
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rst_ok: assert property ($fell(rst) |-> byte_ok == 12'hfff)
    else $error("bad");
  a_rst_rd: assert property ($fell(rst) |-> reg_rdata == 8'h00)
    else $error("bad");
  a_rd_unmap: assert property (reg_rd && reg_addr == 8'h19 |=> reg_rdata == 8'h00)
    else $error("bad");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("bad");
  a_wr_rd: assert property (reg_wr && reg_addr == 8'h38 ##2 reg_rd && !reg_wr &&
    reg_addr == 8'h38 |=> reg_rdata == $past(reg_wdata, 3)) else $error("bad");
  a_ok_fall: assert property ($fell(byte_ok[0]) |-> $past(byte_req[0] || reg_wr))
    else $error("bad");
  a_unlim: assert property ((byte_req[0] && byte_ok[0]) [*3] |=> byte_ok[0])
    else $error("bad");
  a_one_q: assert property (!tx_multi_queue_en[2] [*3] |-> byte_ok[9])
    else $error("bad");
  cover property (reg_wr ##2 reg_rd);
  cover property ($fell(byte_ok[0]));
  cover property ($fell(rst));
endmodule
bind pprl_rate_limiter pprl_chk chk (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .tx_multi_queue_en, .byte_req, .byte_ok);

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value %0t: %s", $time, m); end end
module testbench;
  logic mclk = '0, rst = '1, reg_wr = '0, reg_rd = '0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic [2:0] port_is_10m = 3'h2, tx_multi_queue_en = 3'h3;
  logic [11:0] byte_req = '0, byte_ok;
  logic [7:0] ad[6] = '{8'h17, 8'h18, 8'h27, 8'h28, 8'h37, 8'h38};
  int errors, compares, lo, c, l, r, cnt[12];
  int rk[16] = '{0, 64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000, 32000, 48000,
    64000, 72000, 80000, 88000};
  pprl_rate_limiter uut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_is_10m, .tx_multi_queue_en, .byte_req, .byte_ok);
  task stop_test;
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task io(input w, input [7:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk) reg_wr <= '0;
    reg_rd <= '0;
    @(negedge mclk) if (!w) `CHK(reg_rdata, d, "read data")
    @(posedge mclk);
  endtask
  initial forever #4 mclk = ~mclk;
  initial begin
    #300000 errors++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= '0;
    for (c = 1; c < 16; c++) begin
      for (l = 0; l < 6; l++) io(1, ad[l], {c[3:0], ~c[3:0]});
      io(0, ad[c % 6], {c[3:0], ~c[3:0]});
      cnt = '{default: 0};
      byte_req <= '1;
      repeat (1000) @(negedge mclk) for (l = 0; l < 12; l++) cnt[l] += byte_ok[l];
      @(posedge mclk) byte_req <= '0;
      for (l = 0; l < 12; l++) begin
        r = rk[l % 2 ? c : 15 - c];
        if ((l / 4 == 1 && r > 10000) || l == 9) r = 0;
        lo = r ? r / 1000 - 1 : 1000;
        `CHK(cnt[l] >= lo && cnt[l] <= lo + (r ? 4 : 0), 1'b1, "byte count")
      end
    end
    io(0, 8'h19, 8'h00);
    rst <= '1;
    @(posedge mclk) rst <= '0;
    io(0, 8'h18, 8'h00);
    stop_test;
  end
endmodule
